// ### design/ahpcb_ahb_front.sv
`default_nettype none

module ahpcb_ahb_front (
   input  wire logic                      mclk_i,
   input  wire logic                      rst_n_i,
   input  wire logic                      hsel_i,
   input  wire logic [ahpcb_pkg::ADDR_W-1:0] haddr_i,
   input  wire logic [1:0]                htrans_i,
   input  wire logic                      hwrite_i,
   input  wire logic                      hready_i,
   output var   ahpcb_pkg::ahpcb_access_type addr_phase_o,
   output var   ahpcb_pkg::ahpcb_access_type data_phase_o
);
   import ahpcb_pkg::*;

   // ----------------------------------------------------------------
   // address phase, not gated by hready
   // ----------------------------------------------------------------
   // htrans bit 1 marks nonseq and seq; busy and idle fall out
   wire logic             req_w   = hsel_i & htrans_i[1];
   wire logic [IDX_W-1:0] index_w = haddr_i[IDX_W+1:2];

   assign addr_phase_o = '{valid: req_w, write: hwrite_i, index: index_w};

   // ----------------------------------------------------------------
   // data phase register
   // ----------------------------------------------------------------
   ahpcb_access_type data_phase_reg;
   wire ahpcb_access_type data_phase_next = hready_i ? addr_phase_o : data_phase_reg;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         data_phase_reg <= '0;
      end else begin
         data_phase_reg <= data_phase_next;
      end
   end

   assign data_phase_o = data_phase_reg;

endmodule : ahpcb_ahb_front

`default_nettype wire

// ### design/ahpcb_coef_bank.sv
`default_nettype none

module ahpcb_coef_bank (
   input  wire logic                               mclk_i,
   input  wire logic                               rst_n_i,
   input  wire logic                               hsel_i,
   input  wire logic [ahpcb_pkg::ADDR_W-1:0]       haddr_i,
   input  wire logic [1:0]                         htrans_i,
   input  wire logic                               hwrite_i,
   input  wire logic [2:0]                         hsize_i,
   input  wire logic [ahpcb_pkg::DATA_W-1:0]       hwdata_i,
   input  wire logic                               hready_i,
   output logic                                    hreadyout_o,
   output logic                                    hresp_o,
   output logic      [ahpcb_pkg::DATA_W-1:0]       hrdata_o,
   output var   ahpcb_pkg::ahpcb_coef_bank_type    coef_o
);
   import ahpcb_pkg::*;

   // ----------------------------------------------------------------
   // bus front end
   // ----------------------------------------------------------------
   ahpcb_access_type addr_phase;
   ahpcb_access_type data_phase;

   ahpcb_ahb_front u_front (
      .mclk_i       (mclk_i),
      .rst_n_i      (rst_n_i),
      .hsel_i       (hsel_i),
      .haddr_i      (haddr_i),
      .htrans_i     (htrans_i),
      .hwrite_i     (hwrite_i),
      .hready_i     (hready_i),
      .addr_phase_o (addr_phase),
      .data_phase_o (data_phase)
   );

   // only whole words are issued; size does not change the decode
   wire logic [2:0] size_unused = hsize_i;

   // ----------------------------------------------------------------
   // write timing
   // ----------------------------------------------------------------
   // the write lands on the first edge of its data phase; a read
   // that follows straight on is held one cycle so it sees the new
   // value instead of needing a forwarding path
   logic wr_done_reg;

   wire logic wr_fire    = data_phase.valid & data_phase.write & !wr_done_reg;
   wire logic rd_hazard  = wr_fire & addr_phase.valid & !addr_phase.write;
   wire logic wr_done_next = hready_i ? 1'b0 : (wr_done_reg | wr_fire);
   wire logic [BYTE_W-1:0] wr_byte = hwdata_i[BYTE_W-1:0];

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_done_reg <= 1'b0;
      end else begin
         wr_done_reg <= wr_done_next;
      end
   end

   assign hreadyout_o = !rd_hazard;
   assign hresp_o     = HRESP_OKAY;

   // ----------------------------------------------------------------
   // control register
   // ----------------------------------------------------------------
   ahpcb_apply_mode_type mode_reg;

   wire logic wr_ctrl     = wr_fire & (data_phase.index == IDX_CTRL);
   wire logic commit_w    = wr_ctrl & hwdata_i[CTRL_COMMIT_BIT];
   wire ahpcb_apply_mode_type mode_next =
      wr_ctrl ? ahpcb_apply_mode_type'(hwdata_i[CTRL_MODE_BIT]) : mode_reg;
   wire logic manual_w    = (mode_reg == APPLY_MANUAL);

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mode_reg <= APPLY_AUTO;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // ----------------------------------------------------------------
   // coefficient storage, left slots 0..2, right slots 3..5
   // ----------------------------------------------------------------
   logic        [BYTE_W-1:0] upper_bytes [NUM_COEF];
   logic        [BYTE_W-1:0] lower_bytes [NUM_COEF];
   logic        [1:0]        pend_bits   [NUM_COEF];
   logic signed [COEF_W-1:0] coef_val    [NUM_COEF];

   for (genvar k = 0; k < NUM_COEF; k++) begin : g_coef
      wire logic wr_upper = wr_fire & (data_phase.index == upper_index(k));
      wire logic wr_lower = wr_fire & (data_phase.index == lower_index(k));

      // reset pairs per slot: ff0 39/55, ff1 f3/2d, fb1 53/7e
      ahpcb_coef_pair #(
         .UPPER_RST (upper_reset(k)),
         .LOWER_RST (lower_reset(k))
      ) u_pair (
         .mclk_i     (mclk_i),
         .rst_n_i    (rst_n_i),
         .wr_upper_i (wr_upper),
         .wr_lower_i (wr_lower),
         .wdata_i    (wr_byte),
         .manual_i   (manual_w),
         .commit_i   (commit_w),
         .upper_o    (upper_bytes[k]),
         .lower_o    (lower_bytes[k]),
         .pending_o  (pend_bits[k]),
         .coef_o     (coef_val[k])
      );
   end

   // ----------------------------------------------------------------
   // coefficient outputs, channels kept apart
   // ----------------------------------------------------------------
   // one driver for the whole bank, a packed variable takes no split drivers
   assign coef_o = '{
      left:  '{coef_val[0], coef_val[1], coef_val[2]},
      right: '{coef_val[3], coef_val[4], coef_val[5]}
   };

   // ----------------------------------------------------------------
   // status: pending halves, two bits per slot, upper bit first
   // ----------------------------------------------------------------
   logic [2*NUM_COEF-1:0] status_pend;

   always_comb begin
      status_pend = '0;
      for (int k = 0; k < NUM_COEF; k++) begin
         status_pend[2*k +: 2] = pend_bits[k];
      end
   end

   // ----------------------------------------------------------------
   // read decode
   // ----------------------------------------------------------------
   // unmapped and reserved indices read as zero, writes to them drop
   logic [DATA_W-1:0] rd_value;

   always_comb begin
      rd_value = RDATA_ZERO;
      if (addr_phase.index == IDX_CTRL) begin
         rd_value[CTRL_MODE_BIT] = mode_reg;
      end else if (addr_phase.index == IDX_STATUS) begin
         rd_value[STATUS_PEND_LSB +: 2*NUM_COEF] = status_pend;
      end else begin
         for (int k = 0; k < NUM_COEF; k++) begin
            if (addr_phase.index == upper_index(k)) begin
               rd_value[BYTE_W-1:0] = upper_bytes[k];
            end
            if (addr_phase.index == lower_index(k)) begin
               rd_value[BYTE_W-1:0] = lower_bytes[k];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // read data register
   // ----------------------------------------------------------------
   logic [DATA_W-1:0] hrdata_reg;

   wire logic rd_take = addr_phase.valid & !addr_phase.write & hready_i & !rd_hazard;
   wire logic [DATA_W-1:0] hrdata_next = rd_take ? rd_value : hrdata_reg;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hrdata_reg <= RDATA_ZERO;
      end else begin
         hrdata_reg <= hrdata_next;
      end
   end

   assign hrdata_o = hrdata_reg;

endmodule : ahpcb_coef_bank

`default_nettype wire

// ### design/ahpcb_coef_pair.sv
`default_nettype none

module ahpcb_coef_pair #(
   parameter logic [ahpcb_pkg::BYTE_W-1:0] UPPER_RST = 8'h00,
   parameter logic [ahpcb_pkg::BYTE_W-1:0] LOWER_RST = 8'h00
) (
   input  wire logic                             mclk_i,
   input  wire logic                             rst_n_i,
   input  wire logic                             wr_upper_i,
   input  wire logic                             wr_lower_i,
   input  wire logic [ahpcb_pkg::BYTE_W-1:0]     wdata_i,
   input  wire logic                             manual_i,
   input  wire logic                             commit_i,
   output logic      [ahpcb_pkg::BYTE_W-1:0]     upper_o,
   output logic      [ahpcb_pkg::BYTE_W-1:0]     lower_o,
   output logic      [1:0]                       pending_o,
   output logic signed [ahpcb_pkg::COEF_W-1:0]   coef_o
);
   import ahpcb_pkg::*;

   logic        [BYTE_W-1:0] upper_reg;
   logic        [BYTE_W-1:0] lower_reg;
   logic        [1:0]        pend_reg;
   logic signed [COEF_W-1:0] coef_reg;

   // ----------------------------------------------------------------
   // next values
   // ----------------------------------------------------------------
   wire logic [BYTE_W-1:0] upper_next = wr_upper_i ? wdata_i : upper_reg;
   wire logic [BYTE_W-1:0] lower_next = wr_lower_i ? wdata_i : lower_reg;
   wire logic [1:0]        pend_set   = {wr_upper_i, wr_lower_i} | pend_reg;
   // apply only once both halves are fresh, never a torn pair
   wire logic              apply_w    = (&pend_set) & (!manual_i | commit_i);
   wire logic [1:0]        pend_next  = apply_w ? 2'b00 : pend_set;
   // full 16-bit range passes through unclamped
   wire logic signed [COEF_W-1:0] coef_next =
      apply_w ? $signed({upper_next, lower_next}) : coef_reg;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         upper_reg <= UPPER_RST;
         lower_reg <= LOWER_RST;
         pend_reg  <= 2'b00;
         coef_reg  <= {UPPER_RST, LOWER_RST};
      end else begin
         upper_reg <= upper_next;
         lower_reg <= lower_next;
         pend_reg  <= pend_next;
         coef_reg  <= coef_next;
      end
   end

   assign upper_o   = upper_reg;
   assign lower_o   = lower_reg;
   assign pending_o = pend_reg;
   assign coef_o    = coef_reg;

endmodule : ahpcb_coef_pair

`default_nettype wire

// ### design/ahpcb_pkg.sv
`default_nettype none

package ahpcb_pkg;

   // ----------------------------------------------------------------
   // widths and counts
   // ----------------------------------------------------------------
   localparam int ADDR_W   = 12;
   localparam int IDX_W    = 8;
   localparam int BYTE_W   = 8;
   localparam int COEF_W   = 16;
   localparam int DATA_W   = 32;
   localparam int NUM_COEF = 6;

   // ----------------------------------------------------------------
   // register indices, byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [IDX_W-1:0] IDX_LEFT_FF0_UPPER  = 8'h41;
   localparam logic [IDX_W-1:0] IDX_LEFT_FF0_LOWER  = 8'h42;
   localparam logic [IDX_W-1:0] IDX_LEFT_FF1_UPPER  = 8'h43;
   localparam logic [IDX_W-1:0] IDX_LEFT_FF1_LOWER  = 8'h44;
   localparam logic [IDX_W-1:0] IDX_LEFT_FB1_UPPER  = 8'h45;
   localparam logic [IDX_W-1:0] IDX_LEFT_FB1_LOWER  = 8'h46;
   localparam logic [IDX_W-1:0] IDX_RIGHT_FF0_UPPER = 8'h47;
   localparam logic [IDX_W-1:0] IDX_RIGHT_FF0_LOWER = 8'h48;
   localparam logic [IDX_W-1:0] IDX_RIGHT_FF1_UPPER = 8'h49;
   localparam logic [IDX_W-1:0] IDX_RIGHT_FF1_LOWER = 8'h4a;
   localparam logic [IDX_W-1:0] IDX_RIGHT_FB1_UPPER = 8'h4b;
   localparam logic [IDX_W-1:0] IDX_RIGHT_FB1_LOWER = 8'h4c;
   localparam logic [IDX_W-1:0] IDX_CTRL            = 8'h80;
   localparam logic [IDX_W-1:0] IDX_STATUS          = 8'h81;

   // ----------------------------------------------------------------
   // reset values, shared by both channels
   // ----------------------------------------------------------------
   localparam logic [BYTE_W-1:0] RST_FF0_UPPER = 8'h39;
   localparam logic [BYTE_W-1:0] RST_FF0_LOWER = 8'h55;
   localparam logic [BYTE_W-1:0] RST_FF1_UPPER = 8'hf3;
   localparam logic [BYTE_W-1:0] RST_FF1_LOWER = 8'h2d;
   localparam logic [BYTE_W-1:0] RST_FB1_UPPER = 8'h53;
   localparam logic [BYTE_W-1:0] RST_FB1_LOWER = 8'h7e;

   // ----------------------------------------------------------------
   // control and status register fields
   // ----------------------------------------------------------------
   localparam int CTRL_MODE_BIT   = 0;
   localparam int CTRL_COMMIT_BIT = 1;
   localparam int STATUS_PEND_LSB = 0;

   // ----------------------------------------------------------------
   // bus encodings
   // ----------------------------------------------------------------
   localparam logic [1:0] HTRANS_IDLE  = 2'h0;
   localparam logic       HRESP_OKAY   = 1'h0;
   localparam logic [DATA_W-1:0] RDATA_ZERO = 32'h0000_0000;

   typedef enum logic {
      APPLY_AUTO   = 1'b0,
      APPLY_MANUAL = 1'b1
   } ahpcb_apply_mode_type;

   typedef struct packed {
      logic signed [COEF_W-1:0] feedforward_coef_zero;
      logic signed [COEF_W-1:0] feedforward_coef_one;
      logic signed [COEF_W-1:0] feedback_coef_one;
   } ahpcb_coef_set_type;

   typedef struct packed {
      ahpcb_coef_set_type left;
      ahpcb_coef_set_type right;
   } ahpcb_coef_bank_type;

   typedef struct packed {
      logic             valid;
      logic             write;
      logic [IDX_W-1:0] index;
   } ahpcb_access_type;

   // ----------------------------------------------------------------
   // coefficient slot k: 0..2 left ff0/ff1/fb1, 3..5 right
   // ----------------------------------------------------------------
   function automatic logic [IDX_W-1:0] upper_index(input int k);
      case (k)
         0:       upper_index = IDX_LEFT_FF0_UPPER;
         1:       upper_index = IDX_LEFT_FF1_UPPER;
         2:       upper_index = IDX_LEFT_FB1_UPPER;
         3:       upper_index = IDX_RIGHT_FF0_UPPER;
         4:       upper_index = IDX_RIGHT_FF1_UPPER;
         default: upper_index = IDX_RIGHT_FB1_UPPER;
      endcase
   endfunction : upper_index

   function automatic logic [IDX_W-1:0] lower_index(input int k);
      case (k)
         0:       lower_index = IDX_LEFT_FF0_LOWER;
         1:       lower_index = IDX_LEFT_FF1_LOWER;
         2:       lower_index = IDX_LEFT_FB1_LOWER;
         3:       lower_index = IDX_RIGHT_FF0_LOWER;
         4:       lower_index = IDX_RIGHT_FF1_LOWER;
         default: lower_index = IDX_RIGHT_FB1_LOWER;
      endcase
   endfunction : lower_index

   function automatic logic [BYTE_W-1:0] upper_reset(input int k);
      case (k % 3)
         0:       upper_reset = RST_FF0_UPPER;
         1:       upper_reset = RST_FF1_UPPER;
         default: upper_reset = RST_FB1_UPPER;
      endcase
   endfunction : upper_reset

   function automatic logic [BYTE_W-1:0] lower_reset(input int k);
      case (k % 3)
         0:       lower_reset = RST_FF0_LOWER;
         1:       lower_reset = RST_FF1_LOWER;
         default: lower_reset = RST_FB1_LOWER;
      endcase
   endfunction : lower_reset

endpackage : ahpcb_pkg

`default_nettype wire

// ### verification/ahpcb_coef_bank_properties.sv
`default_nettype none

module ahpcb_coef_bank_checker (
   input wire logic                                mclk_i,
   input wire logic                                rst_n_i,
   input wire logic                                hsel_i,
   input wire logic [ahpcb_pkg::ADDR_W-1:0]        haddr_i,
   input wire logic [1:0]                          htrans_i,
   input wire logic                                hwrite_i,
   input wire logic [2:0]                          hsize_i,
   input wire logic [ahpcb_pkg::DATA_W-1:0]        hwdata_i,
   input wire logic                                hready_i,
   input wire logic                                hreadyout_o,
   input wire logic                                hresp_o,
   input wire logic [ahpcb_pkg::DATA_W-1:0]        hrdata_o,
   input wire ahpcb_pkg::ahpcb_coef_bank_type      coef_o
);
   import ahpcb_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;

   // ----------------------------------------------------------------
   // data phase tracking
   // ----------------------------------------------------------------
   logic             dp_wr_reg;
   logic [IDX_W-1:0] dp_idx_reg;
   wire logic        wr_take;
   wire logic        left_hit;
   wire logic        right_hit;

   assign wr_take   = hsel_i && htrans_i[1] && hready_i && hwrite_i;
   // ctrl counts too, a commit may apply pending pairs
   assign left_hit  = (dp_idx_reg >= IDX_LEFT_FF0_UPPER && dp_idx_reg <= IDX_LEFT_FB1_LOWER) || dp_idx_reg == IDX_CTRL;
   assign right_hit = (dp_idx_reg >= IDX_RIGHT_FF0_UPPER && dp_idx_reg <= IDX_RIGHT_FB1_LOWER) || dp_idx_reg == IDX_CTRL;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         dp_wr_reg  <= 1'b0;
         dp_idx_reg <= '0;
      end else if (hready_i) begin
         dp_wr_reg  <= wr_take;
         dp_idx_reg <= haddr_i[9:2];
      end
   end

   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);

   sequence s_wr_taken;
      hsel_i && htrans_i[1] && hready_i && hwrite_i;
   endsequence
   sequence s_rd_req;
      hsel_i && htrans_i[1] && !hwrite_i;
   endsequence

   property p_rst_ff0_left;
      $rose(rst_n_i) |-> coef_o.left.feedforward_coef_zero == 16'h3955;
   endproperty
   property p_rst_ff0_right;
      $rose(rst_n_i) |-> coef_o.right.feedforward_coef_zero == 16'h3955;
   endproperty
   property p_rst_ff1;
      $rose(rst_n_i) |-> coef_o.left.feedforward_coef_one == 16'hf32d && coef_o.right.feedforward_coef_one == 16'hf32d;
   endproperty
   property p_rst_fb1;
      $rose(rst_n_i) |-> coef_o.left.feedback_coef_one == 16'h537e && coef_o.right.feedback_coef_one == 16'h537e;
   endproperty
   property p_left_src;
      !$stable(coef_o.left) |-> $past(dp_wr_reg) && $past(left_hit);
   endproperty
   property p_right_src;
      !$stable(coef_o.right) |-> $past(dp_wr_reg) && $past(right_hit);
   endproperty
   property p_one_wait;
      s_wr_taken ##1 s_rd_req |-> !hreadyout_o ##1 hreadyout_o;
   endproperty
   property p_stall_cause;
      !hreadyout_o |-> dp_wr_reg && hsel_i && htrans_i[1] && !hwrite_i;
   endproperty
   property p_okay;
      hresp_o == HRESP_OKAY;
   endproperty

   a_rst_ff0_left:  assert property (p_rst_ff0_left) else $error("left ff0 reset value wrong");
   a_rst_ff0_right: assert property (p_rst_ff0_right) else $error("right ff0 reset value wrong");
   a_rst_ff1:       assert property (p_rst_ff1) else $error("ff1 reset value wrong");
   a_rst_fb1:       assert property (p_rst_fb1) else $error("fb1 reset value wrong");
   a_left_src:      assert property (p_left_src) else $error("left set changed without a left write");
   a_right_src:     assert property (p_right_src) else $error("right set changed without a right write");
   a_one_wait:      assert property (p_one_wait) else $error("read after write wait state wrong");
   a_stall_cause:   assert property (p_stall_cause) else $error("wait state without cause");
   a_okay:          assert property (p_okay) else $error("response not okay");

endmodule : ahpcb_coef_bank_checker

bind ahpcb_coef_bank ahpcb_coef_bank_checker ahpcb_coef_bank_checker_i (
   .mclk_i(mclk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
   .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i),
   .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o), .coef_o(coef_o)
);

`default_nettype wire

// ### verification/testbench.sv
`default_nettype none

module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import ahpcb_pkg::*;

   localparam logic [BYTE_W-1:0] RST_UP [3] = '{8'h39, 8'hf3, 8'h53};
   localparam logic [BYTE_W-1:0] RST_LO [3] = '{8'h55, 8'h2d, 8'h7e};
   localparam logic [IDX_W-1:0]  GAP_IDX    = 8'h4d;

   logic                mclk_i;
   logic                rst_n_i;
   logic                hsel_i;
   logic [ADDR_W-1:0]   haddr_i;
   logic [1:0]          htrans_i;
   logic                hwrite_i;
   logic [2:0]          hsize_i;
   logic [DATA_W-1:0]   hwdata_i;
   logic                hreadyout_o;
   logic                hresp_o;
   logic [DATA_W-1:0]   hrdata_o;
   ahpcb_coef_bank_type coef_o;
   int                  n_errors;
   int                  total_checks;

   ahpcb_coef_bank ahpcb_coef_bank_i (
      .mclk_i(mclk_i), .rst_n_i(rst_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
      .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hreadyout_o),
      .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .hrdata_o(hrdata_o), .coef_o(coef_o)
   );

   initial begin
      mclk_i = 1'b0;
      forever #5 mclk_i = ~mclk_i;
   end

   // ----------------------------------------------------------------
   // bus and compare helpers
   // ----------------------------------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   // ready and read data taken at the rising edge, before that edge updates them
   task automatic wait_rdy(output logic [31:0] data);
      int n = 0;
      do begin
         @(posedge mclk_i);
         n++;
      end while (hreadyout_o !== 1'b1 && n < 50);
      if (hreadyout_o !== 1'b1) begin
         n_errors++;
         $display("Error at %0t: no ready", $time);
      end
      data = hrdata_o;
   endtask : wait_rdy

   // chain: a read of the same place follows the write back to back
   task automatic bus(input logic wr, input logic [IDX_W-1:0] idx, input logic [31:0] wdata,
                      input logic chain, output logic [31:0] rdata);
      logic [31:0] dummy;
      hsel_i   <= 1'b1;
      htrans_i <= 2'h2;
      hwrite_i <= wr;
      haddr_i  <= {2'h0, idx, 2'h0};
      wait_rdy(dummy);
      if (chain) begin
         hwrite_i <= 1'b0;
         hwdata_i <= wdata;
         wait_rdy(dummy);
      end
      htrans_i <= HTRANS_IDLE;
      hwdata_i <= wdata;
      wait_rdy(rdata);
   endtask : bus

   task automatic wr(input logic [IDX_W-1:0] idx, input logic [7:0] data);
      logic [31:0] r;
      bus(1'b1, idx, {24'h0, data}, 1'b0, r);
   endtask : wr

   task automatic rd(input logic [IDX_W-1:0] idx, output logic [31:0] r);
      bus(1'b0, idx, 32'h0, 1'b0, r);
   endtask : rd

   task automatic chk_slot(input int k, input logic [15:0] exp);
      logic [95:0] flat;
      @(negedge mclk_i);
      flat = coef_o;
      check({16'h0, flat[95-16*k -: 16]}, {16'h0, exp});
      @(posedge mclk_i);
   endtask : chk_slot

   task automatic do_reset();
      @(posedge mclk_i);
      rst_n_i <= 1'b0;
      repeat (10) @(posedge mclk_i);
      rst_n_i <= 1'b1;
      @(posedge mclk_i);
   endtask : do_reset

   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_reset_values();
      logic [31:0] r;
      for (int k = 0; k < 6; k++) begin
         rd(8'(IDX_LEFT_FF0_UPPER + 2 * k), r);
         check(r, {24'h0, RST_UP[k % 3]});
         rd(8'(IDX_LEFT_FF0_LOWER + 2 * k), r);
         check(r, {24'h0, RST_LO[k % 3]});
         chk_slot(k, {RST_UP[k % 3], RST_LO[k % 3]});
      end
   endtask : t_reset_values

   task automatic t_half_pair();
      logic [31:0] r;
      wr(IDX_LEFT_FF1_UPPER, 8'h80);
      chk_slot(1, 16'hf32d);
      rd(IDX_LEFT_FF1_UPPER, r);
      check(r, 32'h0000_0080);
      wr(IDX_LEFT_FF1_LOWER, 8'h00);
      chk_slot(1, 16'h8000);
      wr(IDX_RIGHT_FB1_LOWER, 8'hff);
      chk_slot(5, 16'h537e);
      wr(IDX_RIGHT_FB1_UPPER, 8'h7f);
      chk_slot(5, 16'h7fff);
      chk_slot(2, 16'h537e);
   endtask : t_half_pair

   task automatic t_all_slots();
      logic [31:0] r;
      for (int k = 0; k < 6; k++) begin
         wr(8'(IDX_LEFT_FF0_UPPER + 2 * k), 8'(8'hc0 + k));
         wr(8'(IDX_LEFT_FF0_LOWER + 2 * k), 8'(8'h0f + 16 * k));
      end
      for (int k = 0; k < 6; k++) begin
         chk_slot(k, {8'(8'hc0 + k), 8'(8'h0f + 16 * k)});
         rd(8'(IDX_LEFT_FF0_LOWER + 2 * k), r);
         check(r, {24'h0, 8'(8'h0f + 16 * k)});
      end
   endtask : t_all_slots

   task automatic t_hazard();
      logic [31:0] r;
      bus(1'b1, IDX_RIGHT_FF0_UPPER, 32'h0000_005a, 1'b1, r);
      check(r, 32'h0000_005a);
      chk_slot(3, 16'hc33f);
      wr(IDX_RIGHT_FF0_LOWER, 8'h01);
      chk_slot(3, 16'h5a01);
      wr(GAP_IDX, 8'hff);
      rd(GAP_IDX, r);
      check(r, RDATA_ZERO);
   endtask : t_hazard

   // manual apply: both bytes pend until a commit
   task automatic t_manual();
      logic [31:0] r;
      wr(IDX_CTRL, 8'h01);
      rd(IDX_CTRL, r);
      check(r, 32'h0000_0001);
      wr(IDX_LEFT_FF0_UPPER, 8'h12);
      wr(IDX_LEFT_FF0_LOWER, 8'h34);
      chk_slot(0, 16'hc00f);
      rd(IDX_STATUS, r);
      check(r, 32'h0000_0003);
      wr(IDX_CTRL, 8'h03);
      chk_slot(0, 16'h1234);
      rd(IDX_STATUS, r);
      check(r, 32'h0000_0000);
      wr(IDX_CTRL, 8'h00);
   endtask : t_manual

   // ----------------------------------------------------------------
   // run control
   // ----------------------------------------------------------------
   task automatic tally_and_finish();
      $display("checks %0d, errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : tally_and_finish

   initial begin
      #50000;
      n_errors++;
      $display("Error at %0t: watchdog expired", $time);
      tally_and_finish();
   end

   initial begin
      rst_n_i      = 1'b0;
      hsel_i       = 1'b0;
      haddr_i      = '0;
      htrans_i     = HTRANS_IDLE;
      hwrite_i     = 1'b0;
      hsize_i      = 3'h2;
      hwdata_i     = '0;
      n_errors     = 0;
      total_checks = 0;
      do_reset();
      t_reset_values();
      t_half_pair();
      t_all_slots();
      t_hazard();
      t_manual();
      do_reset();
      t_reset_values();
      tally_and_finish();
   end

endmodule : testbench

`default_nettype wire
